// >>> hw/irqhs_pkg.sv
// Purpose: Shared constants and types of the interrupt request and acknowledge block
// Assumes: One 250 MHz clock, asynchronous active-high reset
// Notes:   Group layout and pin bundle are shared by the top level and its leaves
//
// Notes on behaviour
// [R1] Transfer ack held until strobes released
// [R2] One request line merges all sources
// [R3] Sources maskable, pending status reported
// [R4] Request drive: push-pull low/high, open drain
// [R5] Daisy chain: request only with chain input
// [R6] Drop request: chain input low, nothing pending
// [R7] Accepted acknowledge puts vector on data
// [R8] Sources form eight fixed-priority groups
// [R9] Vector names highest-priority active group
// [R10] Single strobe: release at next cycle end
// [R11] Single strobe: vector timed by data strobe
// [R12] Split strobes: two cycles, release after second
// [R13] Slave cascade: accept on address match
// [R14] Daisy chain: accept with chain input high
// [R15] Host keeps select, DMA grants idle
// [R16] Chain output low when requesting or blocked
// [R17] Refused acknowledge: bus undriven, status kept

package irqhs_pkg;

  // ==========================================================================
  // Sizes
  localparam int          NUM_GROUPS    = 8;      // Fixed priority groups
  localparam int          GROUP_W       = 3;      // Group index width

  // ==========================================================================
  // Mode codes
  localparam logic [1:0]  DRIVE_PP_LOW  = 2'h0;   // Push-pull, active low
  localparam logic [1:0]  DRIVE_PP_HIGH = 2'h1;   // Push-pull, active high
  localparam logic [1:0]  DRIVE_OPEN    = 2'h2;   // Open drain
  localparam logic        CASC_SLAVE    = 1'h0;   // Slave addressing
  localparam logic        CASC_DAISY    = 1'h1;   // Daisy chain
  localparam logic        BUS_SPLIT     = 1'h0;   // Separate read/write strobes
  localparam logic        BUS_SINGLE    = 1'h1;   // Single data strobe

  // ==========================================================================
  // Reset values
  localparam logic [39:0] STATUS_RESET  = 40'h00_0000_0000;
  localparam logic [7:0]  VEC_RESET     = 8'h00;
  localparam logic [7:0]  PINS_RESET    = 8'hFC;  // Strobes idle, chain pins low

  // ==========================================================================
  // Group bit ranges in the flattened source vector, group 0 highest
  localparam int GRP_LO [NUM_GROUPS] = '{4, 0, 8, 20, 16, 24, 36, 32};
  localparam int GRP_HI [NUM_GROUPS] = '{7, 3, 15, 23, 19, 31, 39, 35};

  // ==========================================================================
  // Types
  // Interrupt sources: two channels with two status words each, plus port
  typedef struct packed {
    logic [7:0] port;        // Port interrupt status
    logic [7:0] chb_second;  // Channel B second status
    logic [7:0] chb_first;   // Channel B first status
    logic [7:0] cha_second;  // Channel A second status
    logic [7:0] cha_first;   // Channel A first status
  } irqhs_src_t;

  // Asynchronous pins, bundled for the synchroniser
  typedef struct packed {
    logic ack_n;      // Vector acknowledge
    logic cs_n;       // Chip select
    logic ds_n;       // Data strobe or read strobe
    logic wr_n;       // Write strobe or read/write select
    logic dma_a_n;    // DMA grant A
    logic dma_b_n;    // DMA grant B
    logic chain_in;   // Chain enable input
    logic chain_pin;  // Chain enable output pin, read back as address bit
  } irqhs_pins_t;

  // Acknowledge sequencer states
  typedef enum logic [4:0] {
    ACK_IDLE   = 5'b00001,  // No acknowledge in progress
    ACK_FIRST  = 5'b00010,  // First of two cycles, accepted
    ACK_GAP    = 5'b00100,  // Between the two cycles
    ACK_SERVE  = 5'b01000,  // Vector cycle
    ACK_IGNORE = 5'b10000   // Cycle not for this device
  } irqhs_state_t;

endpackage

// >>> hw/irqhs_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to CLK
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module irqhs_sync #(
  parameter int           W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;      // First stage, read by s2 only
  logic [W-1:0] s2;      // Second stage
  logic [W-1:0] s3;      // Third stage
  logic [W-1:0] next_q;  // Filtered value

  // ==========================================================================
  // Filter: accept a bit only when two settled stages match
  genvar b;
  for (b = 0; b < W; b++) begin : g_bit
    assign next_q[b] = (s2[b] == s3[b]) ? s3[b] : q[b];
  end

  // Stage registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q  <= RST_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end

endmodule
`default_nettype wire

// >>> hw/irqhs_prio.sv
// Purpose: Group builder and fixed-priority picker
// Assumes: Sources already masked
// Notes:   Group 0 wins over all others
`timescale 1ns/1ps
`default_nettype none

module irqhs_prio (
  // Masked sources
  input  wire irqhs_pkg::irqhs_src_t         src,
  // Result
  output logic [irqhs_pkg::NUM_GROUPS-1:0]   group_act,
  output logic [irqhs_pkg::GROUP_W-1:0]      top,
  output logic                               any
);

  logic [39:0] flat;  // Sources as one vector

  assign flat = src;

  // ==========================================================================
  // [R8] eight source groups
  genvar g;
  for (g = 0; g < irqhs_pkg::NUM_GROUPS; g++) begin : g_grp
    assign group_act[g] = |flat[irqhs_pkg::GRP_HI[g]:irqhs_pkg::GRP_LO[g]];
  end

  // ==========================================================================
  // [R9] highest group wins
  always_comb begin
    top = '0;
    for (int i = irqhs_pkg::NUM_GROUPS - 1; i >= 0; i--) begin
      if (group_act[i]) begin
        top = i[irqhs_pkg::GROUP_W-1:0];
      end
    end
    any = |group_act;
  end

endmodule
`default_nettype wire

// >>> hw/irqhs_top.sv
// Purpose: Interrupt request line, vector acknowledge and transfer acknowledge
// Assumes: Config ports come from logic on CLK; bus and chain pins are asynchronous
// Notes:   Every pin is registered; all pins float during reset
`timescale 1ns/1ps
`default_nettype none

module irqhs_top (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST,
  // Bus pins, asynchronous
  input  wire logic                   VECTOR_ACK_N,
  input  wire logic                   CHIP_SEL_N,
  input  wire logic                   DATA_STROBE_N,
  input  wire logic                   WRITE_STROBE_N,
  input  wire logic                   DMA_GRANT_A_N,
  input  wire logic                   DMA_GRANT_B_N,
  // Chain pins
  input  wire logic                   CHAIN_ENABLE_IN,
  input  wire logic                   CHAIN_ENABLE_OUT_I,
  output logic                        CHAIN_ENABLE_OUT,
  output logic                        CHAIN_ENABLE_OUT_OE_N,
  // Configuration, same clock
  input  wire logic                   BUS_SINGLE_STROBE,
  input  wire logic                   CASCADE_DAISY,
  input  wire logic [1:0]             SLAVE_ADDR,
  input  wire logic [1:0]             IRQ_DRIVE,
  input  wire logic                   PORT_IRQ_EN,
  input  wire logic [4:0]             VEC_BASE,
  // Interrupt sources, same clock
  input  wire irqhs_pkg::irqhs_src_t  EVENT_SET,
  input  wire irqhs_pkg::irqhs_src_t  STATUS_CLR,
  input  wire irqhs_pkg::irqhs_src_t  IRQ_MASK,
  // Status
  output irqhs_pkg::irqhs_src_t       IRQ_STATUS,
  output logic [7:0]                  GLOBAL_IRQ_STATUS,
  // Request pin
  output logic                        IRQ_OUT,
  output logic                        IRQ_OE_N,
  // Transfer acknowledge, open drain
  output logic                        TRANSFER_ACK_OUT,
  output logic                        TRANSFER_ACK_OE_N,
  // Vector onto data lines 0 to 7
  output logic [7:0]                  DATA_OUT,
  output logic                        DATA_OE_N
);

  // ==========================================================================
  // Declarations
  irqhs_pkg::irqhs_pins_t  pin;          // Synchronised pins
  irqhs_pkg::irqhs_src_t   status_q;     // Sticky status
  irqhs_pkg::irqhs_src_t   next_status;  // Next status
  irqhs_pkg::irqhs_src_t   masked;       // Status behind masks
  irqhs_pkg::irqhs_state_t state;        // Acknowledge sequencer
  irqhs_pkg::irqhs_state_t next_state;   // Next sequencer state
  logic [7:0]              group_act;    // Active groups
  logic [7:0]              next_global;  // Group view to be registered
  logic [2:0]              top;          // Winning group
  logic                    pending;      // Any masked source set
  logic                    ack_prev;     // Acknowledge one cycle ago
  logic                    ack_fall;     // Acknowledge cycle starts
  logic                    ack_rise;     // Acknowledge cycle ends
  logic                    cycle_valid;  // Acknowledge cycle is legal
  logic                    chain_ok;     // Chain allows a request
  logic                    addr_hit;     // Slave address matches
  logic                    accept;       // Acknowledge is for us
  logic                    irq_q;        // Internal request
  logic                    next_irq;     // Next request
  logic [7:0]              vec_q;        // Latched vector
  logic [7:0]              next_vec;     // Next vector
  logic                    drive_vec;    // Vector onto the bus
  logic                    bus_cycle;    // Register access under way
  logic                    ack_term;     // Acknowledge cycle to answer

  // ==========================================================================
  // Pin synchroniser
  irqhs_sync #(
    .W       (8),
    .RST_VAL (irqhs_pkg::PINS_RESET)
  ) irqhs_sync_inst (
    .clk (CLK),
    .rst (RST),
    .d   ({VECTOR_ACK_N, CHIP_SEL_N, DATA_STROBE_N, WRITE_STROBE_N,
           DMA_GRANT_A_N, DMA_GRANT_B_N, CHAIN_ENABLE_IN, CHAIN_ENABLE_OUT_I}),
    .q   (pin)
  );

  // ==========================================================================
  // Status and masking
  always_comb begin
    // Set wins over clear so no event is lost
    next_status = (status_q & ~STATUS_CLR) | EVENT_SET;
    // [R3] mask each source
    masked      = status_q & ~IRQ_MASK;
    // [R2] port joins when enabled
    if (!PORT_IRQ_EN) begin
      masked.port = '0;
    end
  end

  // Group picker
  irqhs_prio irqhs_prio_inst (
    .src       (masked),
    .group_act (group_act),
    .top       (top),
    .any       (pending)
  );

  // [R3] global group status
  assign next_global = group_act;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_q          <= irqhs_pkg::STATUS_RESET;
      GLOBAL_IRQ_STATUS <= '0;
    end else begin
      status_q          <= next_status;
      GLOBAL_IRQ_STATUS <= next_global;
    end
  end

  assign IRQ_STATUS = status_q;

  // ==========================================================================
  // Acknowledge sequencer
  assign ack_fall = ack_prev & ~pin.ack_n;
  assign ack_rise = ~ack_prev & pin.ack_n;
  // [R15] select and grants idle
  assign cycle_valid = pin.cs_n & pin.dma_a_n & pin.dma_b_n;
  // [R13] address from both chain pins
  assign addr_hit = ({pin.chain_in, pin.chain_pin} == SLAVE_ADDR);
  // [R14] chain input high accepts
  assign accept = irq_q & cycle_valid &
                  ((CASCADE_DAISY == irqhs_pkg::CASC_DAISY) ? pin.chain_in : addr_hit);
  assign chain_ok = (CASCADE_DAISY != irqhs_pkg::CASC_DAISY) | pin.chain_in;

  always_comb begin
    next_state = state;
    next_vec   = vec_q;
    unique case (state)
      // Wait for a cycle to begin
      irqhs_pkg::ACK_IDLE: begin
        if (ack_fall && accept) begin
          // [R9] latch winning group
          next_vec   = {VEC_BASE, top};
          // [R12] split strobes take two cycles
          next_state = (BUS_SINGLE_STROBE == irqhs_pkg::BUS_SINGLE) ?
                       irqhs_pkg::ACK_SERVE : irqhs_pkg::ACK_FIRST;
        end else if (ack_fall) begin
          // [R17] refused cycle is watched only
          next_state = irqhs_pkg::ACK_IGNORE;
        end
      end
      // First split cycle carries no vector
      irqhs_pkg::ACK_FIRST: begin
        if (ack_rise) begin
          next_state = irqhs_pkg::ACK_GAP;
        end
      end
      // Between the two split cycles
      irqhs_pkg::ACK_GAP: begin
        if (ack_fall) begin
          next_state = irqhs_pkg::ACK_SERVE;
        end
      end
      // Vector cycle; ends on its rising edge
      irqhs_pkg::ACK_SERVE: begin
        if (ack_rise) begin
          next_state = irqhs_pkg::ACK_IDLE;
        end
      end
      // Someone else's cycle
      irqhs_pkg::ACK_IGNORE: begin
        if (ack_rise) begin
          next_state = irqhs_pkg::ACK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state    <= irqhs_pkg::ACK_IDLE;
      ack_prev <= 1'b1;
      vec_q    <= irqhs_pkg::VEC_RESET;
    end else begin
      state    <= next_state;
      ack_prev <= pin.ack_n;
      vec_q    <= next_vec;
    end
  end

  // ==========================================================================
  // Request line
  always_comb begin
    next_irq = irq_q;
    if (!chain_ok) begin
      // [R6] chain input low aborts
      next_irq = 1'b0;
    end else if (state == irqhs_pkg::ACK_SERVE && ack_rise) begin
      // [R10] release unless more pending
      next_irq = pending;
    end else if (state == irqhs_pkg::ACK_IDLE && pin.ack_n) begin
      // [R5] raise only when chain allows
      // [R6] drop once nothing pending
      next_irq = pending;
    end
    // Held during any acknowledge cycle unless daisy chain input is low: no new trigger while a device is served
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= next_irq;
    end
  end

  // ==========================================================================
  // Bus answers
  always_comb begin
    // [R11] single strobe times the vector
    if (BUS_SINGLE_STROBE == irqhs_pkg::BUS_SINGLE) begin
      drive_vec = (state == irqhs_pkg::ACK_SERVE) & ~pin.ack_n & ~pin.ds_n;
      bus_cycle = ~pin.cs_n & ~pin.ds_n;
    end else begin
      drive_vec = (state == irqhs_pkg::ACK_SERVE) & ~pin.ack_n;
      bus_cycle = ~pin.cs_n & (~pin.ds_n | ~pin.wr_n);
    end
    ack_term = drive_vec | ((state == irqhs_pkg::ACK_FIRST) & ~pin.ack_n);
  end

  // ==========================================================================
  // Pin registers; request, vector value and chain pins computed from next values so they track at once
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ_OUT               <= 1'b0;
      IRQ_OE_N              <= 1'b1;
      TRANSFER_ACK_OUT      <= 1'b0;
      TRANSFER_ACK_OE_N     <= 1'b1;
      DATA_OUT              <= irqhs_pkg::VEC_RESET;
      DATA_OE_N             <= 1'b1;
      CHAIN_ENABLE_OUT      <= 1'b0;
      CHAIN_ENABLE_OUT_OE_N <= 1'b1;
    end else begin
      // [R4] drive style of request
      unique case (IRQ_DRIVE)
        irqhs_pkg::DRIVE_PP_LOW: begin
          IRQ_OUT  <= ~next_irq;
          IRQ_OE_N <= 1'b0;
        end
        irqhs_pkg::DRIVE_PP_HIGH: begin
          IRQ_OUT  <= next_irq;
          IRQ_OE_N <= 1'b0;
        end
        default: begin
          // Open drain; unused code treated the same
          IRQ_OUT  <= 1'b0;
          IRQ_OE_N <= ~next_irq;
        end
      endcase
      // [R1] hold until strobes released
      TRANSFER_ACK_OE_N <= ~(bus_cycle | ack_term);
      // [R7] vector on the low data lines
      DATA_OUT          <= next_vec;
      DATA_OE_N         <= ~drive_vec;
      // [R16] chain output low when requesting
      if (CASCADE_DAISY == irqhs_pkg::CASC_DAISY) begin
        CHAIN_ENABLE_OUT      <= pin.chain_in & ~next_irq;
        CHAIN_ENABLE_OUT_OE_N <= 1'b0;
      end else begin
        CHAIN_ENABLE_OUT      <= 1'b0;
        CHAIN_ENABLE_OUT_OE_N <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  property p_tack_release;
    @(posedge CLK) disable iff (RST)
    (pin.cs_n && pin.ds_n && pin.wr_n && pin.ack_n) |=> TRANSFER_ACK_OE_N;
  endproperty
  a_tack_release: assert property (p_tack_release) else $error("ack not released"); // [R1]

  property p_tack_assert;
    @(posedge CLK) disable iff (RST)
    (!pin.cs_n && !pin.ds_n) |=> !TRANSFER_ACK_OE_N;
  endproperty
  a_tack_assert: assert property (p_tack_assert) else $error("ack not given"); // [R1]

  property p_idle_drop;
    @(posedge CLK) disable iff (RST)
    (state == irqhs_pkg::ACK_IDLE && !pending) |=> !irq_q;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("request without source"); // [R6]

  property p_open_drain;
    @(posedge CLK) disable iff (RST)
    ($past(IRQ_DRIVE) == irqhs_pkg::DRIVE_OPEN) |-> (!IRQ_OUT && IRQ_OE_N == !irq_q);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("bad open drain"); // [R4]

  property p_chain_gate;
    @(posedge CLK) disable iff (RST)
    (CASCADE_DAISY && !pin.chain_in) |=> (!irq_q && !CHAIN_ENABLE_OUT);
  endproperty
  a_chain_gate: assert property (p_chain_gate) else $error("chain ignored"); // [R5]

  property p_chain_low;
    @(posedge CLK) disable iff (RST)
    (irq_q && $past(CASCADE_DAISY)) |-> !CHAIN_ENABLE_OUT;
  endproperty
  a_chain_low: assert property (p_chain_low) else $error("chain out high"); // [R16]

  property p_vec_pick;
    @(posedge CLK) disable iff (RST)
    (state == irqhs_pkg::ACK_IDLE && ack_fall && accept) |=> (vec_q[2:0] == $past(top));
  endproperty
  a_vec_pick: assert property (p_vec_pick) else $error("wrong group"); // [R9]

  property p_release;
    @(posedge CLK) disable iff (RST)
    (state == irqhs_pkg::ACK_SERVE && ack_rise && !pending) |=>
      (!irq_q && state == irqhs_pkg::ACK_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("request kept"); // [R10]

  property p_refuse;
    @(posedge CLK) disable iff (RST)
    (state == irqhs_pkg::ACK_IDLE && ack_fall && !accept) |=>
      (state == irqhs_pkg::ACK_IGNORE && DATA_OE_N);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused cycle served"); // [R17]

endmodule
`default_nettype wire

// >>> bench/irqhs_host.sv
// Purpose: Host model driving acknowledge and register bus cycles
// Assumes: Pins change at the falling CLK edge; pull-ups on all strobes
// Notes:   No ready wait; the caller fixes the cycle length
`timescale 1ns/1ps
`default_nettype none

module irqhs_host (
  // Clock
  input  wire logic       clk,
  // Pins {ack, select, strobe, write, grant a, grant b}, active low
  output logic      [5:0] pins
);
  // ==========================================================================
  // Bus cycles
  // Released strobes return to their pull-up level
  initial begin
    pins = 6'h3F;
  end

  // One cycle held for len falling edges, then idle just as long
  // act drives all six pins, select and grants included
  task automatic bus_cycle(input logic [5:0] act, input int len);
    @(negedge clk);
    pins = act;
    repeat (len) @(negedge clk);
    pins = 6'h3F;
    repeat (len) @(negedge clk);
  endtask
endmodule

`default_nettype wire

// >>> bench/irqhs_top_test.sv
// Purpose: Self-checking bench of the request and acknowledge block
// Assumes: Host model drives bus pins; bench drives the rest at falling edge
// Notes:   A watcher checks each vector against a queue of expectations
`timescale 1ns/1ps
`default_nettype none

module irqhs_top_test;
  // ==========================================================================
  // Signals
  logic                  clk = 1'b0;            // 250 MHz
  logic                  rst = 1'b1;            // Async reset
  logic [5:0]            pins;                  // Host bus pins
  logic                  chain_in, slave_pin;   // Chain input, slave pin level
  logic                  chain_out, chain_oe_n; // Chain output pin
  wire logic             chain_pin;             // Resolved chain pin
  logic                  single, daisy, port_en;
  logic [1:0]            slave_addr, drive;
  logic [4:0]            vbase;
  irqhs_pkg::irqhs_src_t ev, clr, mask, status;
  logic                  irq_out, irq_oe_n, ta_oe_n, ta_out, data_oe_n;
  logic [7:0]            data_out, gstat;
  logic                  prev_oe = 1'b1;        // Vector enable last edge
  logic [7:0]            exp_q [$];             // Expected vectors
  logic [39:0]           pend;                  // Bench copy of status
  int                    fail_count = 0;
  int                    num_checks = 0;

  always #2 clk = ~clk;
  // Pull-down holds the pin low while nobody drives it
  assign chain_pin = chain_oe_n ? slave_pin : chain_out;

  irqhs_host host_inst (.clk(clk), .pins(pins));
  irqhs_top irqhs_top_inst (
    .CLK(clk), .RST(rst), .VECTOR_ACK_N(pins[5]), .CHIP_SEL_N(pins[4]),
    .DATA_STROBE_N(pins[3]), .WRITE_STROBE_N(pins[2]), .DMA_GRANT_A_N(pins[1]),
    .DMA_GRANT_B_N(pins[0]), .CHAIN_ENABLE_IN(chain_in), .CHAIN_ENABLE_OUT_I(chain_pin),
    .CHAIN_ENABLE_OUT(chain_out), .CHAIN_ENABLE_OUT_OE_N(chain_oe_n),
    .BUS_SINGLE_STROBE(single), .CASCADE_DAISY(daisy), .SLAVE_ADDR(slave_addr),
    .IRQ_DRIVE(drive), .PORT_IRQ_EN(port_en), .VEC_BASE(vbase), .EVENT_SET(ev),
    .STATUS_CLR(clr), .IRQ_MASK(mask), .IRQ_STATUS(status), .GLOBAL_IRQ_STATUS(gstat),
    .IRQ_OUT(irq_out), .IRQ_OE_N(irq_oe_n), .TRANSFER_ACK_OUT(ta_out),
    .TRANSFER_ACK_OE_N(ta_oe_n), .DATA_OUT(data_out), .DATA_OE_N(data_oe_n));

  // ==========================================================================
  // Compare and report
  task automatic check_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic check_vec(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR vector expected %h seen %h", e, g);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Request seen as active for the chosen drive style
  function automatic logic irq_on();
    return irq_oe_n === 1'b0 && irq_out === (drive == 2'h1);
  endfunction

  // Source bits of one priority group
  function automatic logic [39:0] gmask(input int g);
    logic [39:0] m;
    m = '0;
    for (int b = irqhs_pkg::GRP_LO[g]; b <= irqhs_pkg::GRP_HI[g]; b++) begin
      m[b] = 1'b1;
    end
    return m;
  endfunction

  // ==========================================================================
  // Stimulus helpers
  // One-cycle set or clear pulse, tracked in the bench copy
  task automatic pulse(input logic [39:0] s, input logic is_clr);
    @(negedge clk);
    ev = irqhs_pkg::irqhs_src_t'(is_clr ? 40'h0 : s);
    clr = irqhs_pkg::irqhs_src_t'(is_clr ? s : 40'h0);
    pend = is_clr ? pend & ~s : pend | s;
    @(negedge clk);
    ev = '0;
    clr = '0;
  endtask

  // Bounded wait for the request level
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq_on() !== e && n < 30) begin
      @(negedge clk);
      n++;
    end
    check_bit("request", e, irq_on());
    if (irq_on() !== e) give_verdict();
  endtask

  // Host cycle; ta says whether transfer ack is due, c is cleared mid-cycle
  task automatic cycle(input logic [5:0] act, input logic ta, input logic [39:0] c);
    fork
      host_inst.bus_cycle(act, 12);
    join_none
    repeat (8) @(negedge clk);
    check_bit("transfer ack", !ta, ta_oe_n);
    check_bit("transfer ack level", 1'b0, ta_out);
    pulse(c, 1'b1);
    if (!act[5]) check_bit("request held", 1'b1, irq_on());
    repeat (12) @(negedge clk);
    check_bit("transfer ack end", 1'b1, ta_oe_n);
    repeat (3) @(negedge clk);
  endtask

  // Each new assertion of the vector enable takes the oldest expectation
  always @(negedge clk) begin
    if (data_oe_n === 1'b0 && prev_oe !== 1'b0) begin
      if (exp_q.size() == 0) begin
        check_bit("unexpected vector", 1'b0, 1'b1);
      end else begin
        check_vec(exp_q.pop_front(), data_out);
      end
    end
    prev_oe <= data_oe_n;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [39:0] left;
    logic [39:0] gm;
    int g;
    {single, daisy, port_en, chain_in, slave_pin} = 5'h14;
    slave_addr = 2'h0;
    drive = 2'h0;
    vbase = 5'h15;
    ev = '0;
    clr = '0;
    mask = '0;
    pend = '0;
    void'($urandom(71));
    repeat (8) @(negedge clk);
    check_bit("reset pins", 1'b1, irq_oe_n & ta_oe_n & data_oe_n);
    rst = 1'b0;
    // Priority walk: all sources first, then random sets
    for (int k = 0; k < 4; k++) begin
      left = (k == 0) ? 40'hFF_FFFF_FFFF : 40'({$urandom(), $urandom()});
      vbase = 5'($urandom());
      pulse(left, 1'b0);
      wait_irq(left != '0);
      while (left != '0) begin
        g = 0;
        while ((gmask(g) & left) == '0 && g < 7) g++;
        gm = gmask(g) & left;
        left = left & ~gm;
        exp_q.push_back({vbase, 3'(g)});
        cycle(6'b010111, 1'b1, gm);
        wait_irq(left != '0);
      end
    end
    // Masked source stays quiet but is reported
    mask = irqhs_pkg::irqhs_src_t'(40'h10);
    pulse(40'h10, 1'b0);
    repeat (8) @(negedge clk);
    wait_irq(1'b0);
    check_bit("global status", 1'b1, gstat === 8'h00);
    check_bit("status", 1'b1, status.cha_first[4]);
    mask = '0;
    wait_irq(1'b1);
    check_bit("global status", 1'b1, gstat === 8'h01);
    // Drive styles, active then idle
    for (int d = 0; d < 8; d++) begin
      drive = d[1:0];
      if (d == 4) pulse(40'h10, 1'b1);
      repeat (4) @(negedge clk);
      check_bit("request enable", d >= 6, irq_oe_n);
      if (d < 6) check_bit("request level", d == 1 || d == 4, irq_out);
    end
    drive = 2'h0;
    // Port sources join only when enabled
    port_en = 1'b0;
    pulse(40'h01_0000_0000, 1'b0);
    repeat (8) @(negedge clk);
    wait_irq(1'b0);
    port_en = 1'b1;
    wait_irq(1'b1);
    // Wrong slave address refused, then matching one accepted
    slave_addr = 2'h2;
    cycle(6'b010111, 1'b0, '0);
    check_bit("status kept", 1'b1, status === irqhs_pkg::irqhs_src_t'(pend));
    check_bit("chain released", 1'b1, chain_oe_n);
    chain_in = 1'b1;
    exp_q.push_back({vbase, 3'h7});
    cycle(6'b010111, 1'b1, '0);
    // Split strobes: two cycles, vector on the second
    single = 1'b0;
    cycle(6'b011111, 1'b1, '0);
    wait_irq(1'b1);
    exp_q.push_back({vbase, 3'h7});
    cycle(6'b011111, 1'b1, 40'h01_0000_0000);
    wait_irq(1'b0);
    // Split write strobe alone, then a single data strobe, also earn a transfer ack
    cycle(6'b101011, 1'b1, '0);
    single = 1'b1;
    cycle(6'b100111, 1'b1, '0);
    // Daisy chain blocked, then enabled and served
    daisy = 1'b1;
    chain_in = 1'b0;
    pulse(40'h100, 1'b0);
    repeat (8) @(negedge clk);
    wait_irq(1'b0);
    check_bit("chain out", 1'b0, chain_out | chain_oe_n);
    chain_in = 1'b1;
    wait_irq(1'b1);
    check_bit("chain out", 1'b0, chain_out | chain_oe_n);
    exp_q.push_back({vbase, 3'h2});
    cycle(6'b010111, 1'b1, '0);
    chain_in = 1'b0;
    wait_irq(1'b0);
    chain_in = 1'b1;
    wait_irq(1'b1);
    pulse(40'h100, 1'b1);
    wait_irq(1'b0);
    repeat (4) @(negedge clk);
    check_bit("chain out", 1'b1, chain_out & !chain_oe_n);
    check_bit("queue empty", 1'b1, exp_q.size() == 0);
    give_verdict();
  end
endmodule

`default_nettype wire
